// ---- hw/ubr_access_port.sv ----
`timescale 1ns/1ns
// How it works
// - OUT or SETUP payload follows its descriptor; next descriptor follows payload.
// - IN descriptor is followed by reserved space of its total byte count.
// - Descriptors and payloads start on four-byte aligned addresses.
// - Iso area reached by command 40H to read, C0H to write.
// - Ack area reached by command 41H to read, C1H to write.
// - Each port word moves two bytes, pointer advances by two.
// - Low byte is the even location, high byte the odd one.
// - Pointer reaching transfer counter sets all-done flag; on ack writes also the ack full state bit.
// - Each start of frame, unless both halves are full, swaps the iso halves between host and engine.
// - Both halves full at frame start: no swap, host uses half b.
// - Inactive header ends the ack list; list without one is not run.
// - Each descriptor header is eight bytes long.
// - Bulk and control totals may exceed packet limit; split into packets.
// - Only when running, send packets, then set ack done status bit 5.
// - After running the ack list, set ack list interrupt bit 1.
// - Host finishing iso writes sets that half's full flag.
module ubr_access_port #(
    parameter int ADDR_W = ubr_pkg::ADDR_W,
    parameter int FIFO_DEPTH = ubr_pkg::FIFO_DEPTH
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic cmd_strobe,
    input wire logic [7:0] cmd_code,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_ready,
    input wire logic bus_running_state,
    input wire logic frame_start,
    output logic [15:0] host_cpu_interrupt_flags,
    output logic [15:0] buffer_state_flags,
    output logic packet_strobe
);
    import ubr_pkg::*;

    logic [6:0] sel_reg;
    logic sel_write;
    logic [15:0] transfer_byte_counter;
    logic [15:0] ack_list_area_length;
    logic [15:0] iso_list_area_length;
    logic [ADDR_W-1:0] byte_ptr;
    logic iso_host_half_b;
    logic iso_written;
    logic end_of_transfer;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [15:0] fifo_out_data;
    logic drain;
    logic [ADDR_W-1:0] wr_addr;
    logic [ADDR_W-1:0] area_base;
    logic [ADDR_W-1:0] eng_addr;
    logic [15:0] ram_rd;
    logic [ADDR_W-1:0] rd_addr;
    ubr_list_state_t list_state;
    logic [2:0] hdr_idx;
    logic [15:0] hdr_w0;
    logic [15:0] hdr_w1;
    logic [15:0] bytes_left;
    logic [15:0] limit;
    logic [15:0] pay_len;
    logic list_start;
    logic list_ok;
    logic scan_pass;
    logic [7:0] pkt_cnt;
    logic [15:0] next_flags;
    logic [15:0] next_state_flags;

    function automatic logic is_buf_port(input logic [6:0] r);
        is_buf_port = (r == PORT_ISO) || (r == PORT_ACK);
    endfunction

    // Host buffer-port write data go through the FIFO; data_ready is its back-pressure
    ubr_fifo #(.WIDTH(16), .DEPTH(FIFO_DEPTH)) u_fifo (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .in_valid(data_wr && sel_write && is_buf_port(sel_reg)),
        .in_ready(fifo_in_ready),
        .in_data(data_in),
        .out_valid(fifo_out_valid),
        .out_ready(1'b1 && list_state == UBR_IDLE),
        .out_data(fifo_out_data)
    );

    assign drain = fifo_out_valid && list_state == UBR_IDLE;

    always_comb begin
        area_base = '0;
        if (sel_reg == PORT_ISO) begin
            area_base = ADDR_W'(ack_list_area_length);
            if (iso_host_half_b) begin
                area_base = ADDR_W'(ack_list_area_length + iso_list_area_length);
            end
        end
    end

    ubr_ram #(.ADDR_W(ADDR_W)) u_ram (
        .core_clk(core_clk),
        .wr_en(drain),
        .wr_addr(wr_addr),
        .wr_data(fifo_out_data),
        .rd_addr(rd_addr),
        .rd_data(ram_rd)
    );

    assign wr_addr = area_base + byte_ptr;
    assign rd_addr = (list_state == UBR_IDLE) ? area_base + byte_ptr : eng_addr;

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            sel_reg <= '0;
            sel_write <= 1'b0;
        end else if (cmd_strobe) begin
            sel_reg <= cmd_code[6:0];
            sel_write <= cmd_code[CMD_WRITE_BIT];
        end
    end

    // Buffer pointer: reset per command, +2 per word
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            byte_ptr <= '0;
        end else if (cmd_strobe) begin
            byte_ptr <= '0;
        end else if (drain || (data_rd && !sel_write && is_buf_port(sel_reg))) begin
            byte_ptr <= byte_ptr + ADDR_W'(2);
        end
    end

    assign end_of_transfer = is_buf_port(sel_reg) && (drain || (data_rd && !sel_write))
        && (16'(byte_ptr) + 16'd2 == transfer_byte_counter);

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            transfer_byte_counter <= RESET_VALUE;
            ack_list_area_length <= RESET_VALUE;
            iso_list_area_length <= RESET_VALUE;
        end else if (data_wr && sel_write) begin
            unique case (sel_reg)
                REG_XFER_COUNT: transfer_byte_counter <= data_in;
                REG_ACK_LEN: ack_list_area_length <= data_in;
                REG_ISO_LEN: iso_list_area_length <= data_in;
                default: ;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            data_out <= '0;
        end else begin
            unique case (sel_reg)
                REG_XFER_COUNT: data_out <= transfer_byte_counter;
                REG_CPU_IRQ: data_out <= host_cpu_interrupt_flags;
                REG_ACK_LEN: data_out <= ack_list_area_length;
                REG_ISO_LEN: data_out <= iso_list_area_length;
                REG_BUF_STATE: data_out <= buffer_state_flags;
                PORT_ISO, PORT_ACK: data_out <= ram_rd;
                default: data_out <= '0;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            data_ready <= 1'b0;
        end else begin
            data_ready <= fifo_in_ready;
        end
    end

    // Iso half swap at frame start
    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            iso_host_half_b <= 1'b0;
        end else if (frame_start) begin
            if (buffer_state_flags[BS_ISO_A_FULL] && buffer_state_flags[BS_ISO_B_FULL]) begin
                iso_host_half_b <= 1'b1;
            end else begin
                iso_host_half_b <= !iso_host_half_b;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            iso_written <= 1'b0;
        end else if (cmd_strobe) begin
            iso_written <= 1'b0;
        end else if (drain && sel_reg == PORT_ISO) begin
            iso_written <= 1'b1;
        end
    end

    // Ack list walk: header words, then payload skip
    assign list_start = end_of_transfer && sel_reg == PORT_ACK && sel_write;
    assign limit = 16'(hdr_w1[DESC_LIMIT_LSB +: DESC_LIMIT_W]);
    assign pay_len = 16'(ubr_align4(ADDR_W'(hdr_w0[DESC_TOTAL_LSB +: DESC_TOTAL_W])));

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            list_state <= UBR_IDLE;
            eng_addr <= '0;
            hdr_idx <= '0;
            hdr_w0 <= '0;
            hdr_w1 <= '0;
            bytes_left <= '0;
            list_ok <= 1'b0;
            pkt_cnt <= '0;
            scan_pass <= 1'b0;
            packet_strobe <= 1'b0;
        end else begin
            packet_strobe <= 1'b0;
            unique case (list_state)
                UBR_IDLE: begin
                    if (list_start && bus_running_state) begin
                        list_state <= UBR_HDR;
                        eng_addr <= '0;
                        hdr_idx <= '0;
                        list_ok <= 1'b0;
                        scan_pass <= 1'b1;
                    end
                end
                UBR_HDR: begin
                    // RAM read latency one cycle: word k arrives at idx k+1
                    eng_addr <= eng_addr + ADDR_W'(2);
                    hdr_idx <= hdr_idx + 3'd1;
                    if (hdr_idx == 3'd1) begin
                        hdr_w0 <= ram_rd;
                    end
                    if (hdr_idx == 3'd2) begin
                        hdr_w1 <= ram_rd;
                    end
                    if (hdr_idx == 3'd4) begin
                        list_state <= UBR_NEXT;
                    end
                end
                UBR_NEXT: begin
                    hdr_idx <= '0;
                    if (16'(eng_addr) >= transfer_byte_counter + 16'(DESC_BYTES + 2)) begin
                        // Header began past the written data: no terminator
                        list_state <= UBR_DONE;
                    end else if (!hdr_w0[DESC_ACTIVE_BIT]) begin
                        if (scan_pass) begin
                            // Terminator seen: walk again, this time sending
                            scan_pass <= 1'b0;
                            eng_addr <= '0;
                            list_state <= UBR_HDR;
                        end else begin
                            list_ok <= 1'b1;
                            list_state <= UBR_DONE;
                        end
                    end else begin
                        // Header already 8 bytes in; skip payload or reserve
                        eng_addr <= ADDR_W'(16'(eng_addr) - 16'd2 + pay_len);
                        bytes_left <= 16'(hdr_w0[DESC_TOTAL_LSB +: DESC_TOTAL_W]);
                        pkt_cnt <= '0;
                        list_state <= scan_pass ? UBR_HDR : UBR_PAY;
                    end
                end
                UBR_PAY: begin
                    // One packet per endpoint limit worth of bytes
                    if (bytes_left == 16'd0 || limit == 16'd0) begin
                        hdr_idx <= '0;
                        list_state <= UBR_HDR;
                    end else begin
                        packet_strobe <= 1'b1;
                        pkt_cnt <= pkt_cnt + 8'd1;
                        bytes_left <= (bytes_left > limit) ? bytes_left - limit : 16'd0;
                    end
                end
                UBR_DONE: begin
                    list_state <= UBR_IDLE;
                end
                default: list_state <= UBR_IDLE;
            endcase
        end
    end

    always_comb begin
        next_flags = host_cpu_interrupt_flags;
        if (data_wr && sel_write && sel_reg == REG_CPU_IRQ) begin
            next_flags = next_flags & ~data_in;
        end
        if (end_of_transfer) begin
            next_flags[IRQ_ALL_DONE] = 1'b1;
        end
        if (list_state == UBR_DONE && list_ok) begin
            next_flags[IRQ_ACK_LIST] = 1'b1;
        end
    end

    always_comb begin
        next_state_flags = buffer_state_flags;
        if (cmd_strobe && cmd_code == {1'b0, PORT_ISO}) begin
            next_state_flags[BS_ISO_A_FULL] = iso_host_half_b ? next_state_flags[0] : 1'b0;
            next_state_flags[BS_ISO_B_FULL] = iso_host_half_b ? 1'b0 : next_state_flags[1];
        end
        if (cmd_strobe && sel_reg == PORT_ISO && sel_write && iso_written) begin
            next_state_flags[iso_host_half_b ? BS_ISO_B_FULL : BS_ISO_A_FULL] = 1'b1;
        end
        if (end_of_transfer && sel_reg == PORT_ACK && sel_write) begin
            next_state_flags[BS_ACK_FULL] = 1'b1;
            next_state_flags[BS_ACK_DONE] = 1'b0;
        end
        if (list_state == UBR_DONE && list_ok) begin
            next_state_flags[BS_ACK_DONE] = 1'b1;
        end
        next_state_flags[15:6] = '0;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            host_cpu_interrupt_flags <= RESET_VALUE;
        end else begin
            host_cpu_interrupt_flags <= next_flags;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            buffer_state_flags <= RESET_VALUE;
        end else begin
            buffer_state_flags <= next_state_flags;
        end
    end

    a_ptr_step: assert property (@(posedge core_clk) disable iff (sys_rst)
        (drain && !cmd_strobe) |=> byte_ptr == $past(byte_ptr) + ADDR_W'(2))
        else $error("pointer did not advance by two");
    a_ptr_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        cmd_strobe |=> byte_ptr == '0)
        else $error("pointer not reset by command");
    a_all_done: assert property (@(posedge core_clk) disable iff (sys_rst)
        end_of_transfer |=> host_cpu_interrupt_flags[IRQ_ALL_DONE])
        else $error("all done flag not set");
    a_swap_half: assert property (@(posedge core_clk) disable iff (sys_rst)
        (frame_start && !(buffer_state_flags[0] && buffer_state_flags[1]))
        |=> iso_host_half_b != $past(iso_host_half_b))
        else $error("iso halves not swapped");
    a_both_full: assert property (@(posedge core_clk) disable iff (sys_rst)
        (frame_start && buffer_state_flags[0] && buffer_state_flags[1]) |=> iso_host_half_b)
        else $error("host not held on half b");
    a_run_gate: assert property (@(posedge core_clk) disable iff (sys_rst)
        (list_state == UBR_IDLE && !bus_running_state) |=> list_state == UBR_IDLE)
        else $error("list walked while not running");
    a_ack_irq: assert property (@(posedge core_clk) disable iff (sys_rst)
        (list_state == UBR_DONE && list_ok) |=> host_cpu_interrupt_flags[IRQ_ACK_LIST]
        && buffer_state_flags[BS_ACK_DONE])
        else $error("ack list flags not set");
    a_split_pkt: assert property (@(posedge core_clk) disable iff (sys_rst)
        (list_state == UBR_PAY && bytes_left > limit && limit != 0) |=> packet_strobe
        ##1 (list_state == UBR_PAY))
        else $error("oversize total not split");
endmodule

// ---- hw/ubr_pkg.sv ----
package ubr_pkg;
    // Command codes: bit 7 set means write
    localparam logic [6:0] REG_XFER_COUNT = 7'h22;
    localparam logic [6:0] REG_CPU_IRQ = 7'h24;
    localparam logic [6:0] REG_ISO_LEN = 7'h2A;
    localparam logic [6:0] REG_ACK_LEN = 7'h2B;
    localparam logic [6:0] REG_BUF_STATE = 7'h2C;
    localparam logic [6:0] PORT_ISO = 7'h40;
    localparam logic [6:0] PORT_ACK = 7'h41;
    localparam int CMD_WRITE_BIT = 7;
    // Interrupt flag bits
    localparam int IRQ_ACK_LIST = 1;
    localparam int IRQ_ALL_DONE = 2;
    // Buffer state bits
    localparam int BS_ISO_A_FULL = 0;
    localparam int BS_ISO_B_FULL = 1;
    localparam int BS_ACK_FULL = 2;
    localparam int BS_ISO_A_DONE = 3;
    localparam int BS_ISO_B_DONE = 4;
    localparam int BS_ACK_DONE = 5;
    // Descriptor layout
    localparam int DESC_BYTES = 8;
    localparam int ALIGN_BYTES = 4;
    localparam int DESC_ACTIVE_BIT = 11;
    localparam int DESC_TOTAL_LSB = 0;
    localparam int DESC_TOTAL_W = 10;
    localparam int DESC_LIMIT_LSB = 0;
    localparam int DESC_LIMIT_W = 10;
    localparam int DESC_DIR_LSB = 10;
    localparam logic [1:0] DIR_IN = 2'b10;
    localparam logic [15:0] RESET_VALUE = 16'h0000;
    localparam int RAM_BYTES = 4096;
    localparam int ADDR_W = 12;
    localparam int FIFO_DEPTH = 8;
    localparam int PACKET_CYCLES = 4;
    typedef enum logic [2:0] {
        UBR_IDLE, UBR_HDR, UBR_PAY, UBR_NEXT, UBR_DONE
    } ubr_list_state_t;
    function automatic logic [ADDR_W-1:0] ubr_align4(input logic [ADDR_W-1:0] a);
        ubr_align4 = (a + ADDR_W'(ALIGN_BYTES - 1)) & ~ADDR_W'(ALIGN_BYTES - 1);
    endfunction
endpackage

// ---- hw/ubr_fifo.sv ----
`timescale 1ns/1ns
module ubr_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr;
    logic [AW:0] rd_ptr;
    logic do_push;
    logic do_pop;

    assign in_ready = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
    assign out_valid = wr_ptr != rd_ptr;
    assign out_data = mem[rd_ptr[AW-1:0]];
    assign do_push = in_valid && in_ready;
    assign do_pop = out_valid && out_ready;

    always_ff @(posedge core_clk) begin
        if (do_push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (do_push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (do_pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

// ---- hw/ubr_ram.sv ----
`timescale 1ns/1ns
module ubr_ram #(
    parameter int ADDR_W = 12
) (
    input wire logic core_clk,
    input wire logic wr_en,
    input wire logic [ADDR_W-1:0] wr_addr,
    input wire logic [15:0] wr_data,
    input wire logic [ADDR_W-1:0] rd_addr,
    output logic [15:0] rd_data
);
    // Byte array; word port: low byte even, high byte odd
    logic [7:0] mem [2**ADDR_W];

    always_ff @(posedge core_clk) begin
        if (wr_en) begin
            mem[{wr_addr[ADDR_W-1:1], 1'b0}] <= wr_data[7:0];
            mem[{wr_addr[ADDR_W-1:1], 1'b1}] <= wr_data[15:8];
        end
    end

    always_ff @(posedge core_clk) begin
        rd_data <= {mem[{rd_addr[ADDR_W-1:1], 1'b1}], mem[{rd_addr[ADDR_W-1:1], 1'b0}]};
    end
endmodule

// ---- tb/ubr_host_model.sv ----
`timescale 1ns/1ns
module ubr_host_model (
    input wire logic core_clk,
    output logic cmd_strobe,
    output logic [7:0] cmd_code,
    output logic data_wr,
    output logic data_rd,
    output logic [15:0] data_in,
    input wire logic [15:0] data_out,
    input wire logic data_ready
);
    initial begin
        cmd_strobe = 1'b0;
        cmd_code = 8'h00;
        data_wr = 1'b0;
        data_rd = 1'b0;
        data_in = 16'h0000;
    end
    // Command issued once, data accesses follow without repeat
    task automatic cmd(input logic [7:0] c);
        @(posedge core_clk) #1;
        cmd_strobe = 1'b1;
        cmd_code = c;
        @(posedge core_clk) #1;
        cmd_strobe = 1'b0;
        cmd_code = ~c;
    endtask
    // Holds off while the buffer refuses
    task automatic wr(input logic [15:0] w);
        int n;
        n = 0;
        @(posedge core_clk) #1;
        while (data_ready !== 1'b1 && n < 200) begin
            @(posedge core_clk) #1;
            n++;
        end
        data_wr = 1'b1;
        data_in = w;
        @(posedge core_clk) #1;
        data_wr = 1'b0;
        data_in = ~w;
    endtask
    task automatic peek(output logic [15:0] w);
        repeat (3) @(posedge core_clk);
        #1;
        w = data_out;
    endtask
    task automatic rd(output logic [15:0] w);
        peek(w);
        data_rd = 1'b1;
        @(posedge core_clk) #1;
        data_rd = 1'b0;
    endtask
endmodule

// ---- tb/usb_host_buffer_ram_access_port_tb_top.sv ----
`timescale 1ns/1ns
`define CHK(got, exp, msg) \
    begin total_checks++; if ((got) !== (exp)) begin failures++; \
    $display("mismatch at %0t: %s", $time, msg); end end
module usb_host_buffer_ram_access_port_tb_top;
    import ubr_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic cmd_strobe, data_wr, data_rd, data_ready, packet_strobe;
    logic [7:0] cmd_code;
    logic [15:0] data_in, data_out, irq, state;
    logic bus_running_state = 1'b0;
    logic frame_start = 1'b0;
    int failures = 0;
    int total_checks = 0;
    int pkts = 0;
    int cycles = 0;
    logic [15:0] lst [16];

    always #10 core_clk = ~core_clk;

    ubr_access_port u_dut (
        .core_clk(core_clk), .sys_rst(sys_rst), .cmd_strobe(cmd_strobe),
        .cmd_code(cmd_code), .data_wr(data_wr), .data_rd(data_rd),
        .data_in(data_in), .data_out(data_out), .data_ready(data_ready),
        .bus_running_state(bus_running_state), .frame_start(frame_start),
        .host_cpu_interrupt_flags(irq), .buffer_state_flags(state),
        .packet_strobe(packet_strobe)
    );
    ubr_host_model u_host (
        .core_clk(core_clk), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
        .data_wr(data_wr), .data_rd(data_rd), .data_in(data_in),
        .data_out(data_out), .data_ready(data_ready)
    );

    always @(posedge core_clk) begin
        if (packet_strobe === 1'b1) pkts++;
        cycles++;
        if (cycles == 20000) begin
            failures++;
            $display("mismatch at %0t: run did not finish", $time);
            results();
        end
    end

    task automatic results();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic reg_wr(input logic [7:0] c, input logic [15:0] v);
        u_host.cmd(c | 8'h80);
        u_host.wr(v);
    endtask
    task automatic reg_rd(input logic [7:0] c, output logic [15:0] v);
        u_host.cmd(c);
        u_host.peek(v);
    endtask
    // Active header totalling 16 bytes, limit 8, payload, then dummy
    task automatic write_list();
        reg_wr(8'h22, 16'h0020);
        u_host.cmd(8'hC1);
        foreach (lst[i]) u_host.wr(lst[i]);
        repeat (6) @(posedge core_clk);
        #1;
    endtask

    task automatic t_reset();
        `CHK(irq, RESET_VALUE, "irq flags after reset")
        `CHK(state, RESET_VALUE, "state flags after reset")
    endtask
    task automatic t_ack_idle();
        logic [15:0] v;
        reg_wr(8'h2B, 16'h0100);
        reg_wr(8'h2A, 16'h0040);
        reg_wr(8'h24, 16'hFFFF);
        write_list();
        `CHK(irq[IRQ_ALL_DONE], 1'b1, "all done flag")
        `CHK(irq[IRQ_ACK_LIST], 1'b0, "ack irq while stopped")
        `CHK(state[BS_ACK_DONE], 1'b0, "ack done while stopped")
        `CHK(pkts, 0, "packets while stopped")
        reg_rd(8'h2C, v);
        `CHK(v[BS_ACK_FULL], 1'b1, "ack full via register")
        u_host.cmd(8'h41);
        for (int i = 0; i < 16; i++) begin
            u_host.rd(v);
            `CHK(v, lst[i], "ack readback word")
        end
        `CHK(data_ready, 1'b1, "port accepting words")
    endtask
    task automatic t_ack_run();
        int n;
        reg_wr(8'h24, 16'hFFFF);
        `CHK(irq, 16'h0000, "irq cleared by ones")
        bus_running_state = 1'b1;
        pkts = 0;
        write_list();
        n = 0;
        while (state[BS_ACK_DONE] !== 1'b1 && n < 500) begin
            @(posedge core_clk);
            n++;
        end
        #1;
        `CHK(state[BS_ACK_DONE], 1'b1, "ack done when running")
        `CHK(irq[IRQ_ACK_LIST], 1'b1, "ack irq when running")
        `CHK(pkts, 2, "total split into two packets")
        bus_running_state = 1'b0;
    endtask
    // Header and payload only, no terminator: nothing may be sent
    task automatic t_no_dummy();
        reg_wr(8'h24, 16'hFFFF);
        reg_wr(8'h22, 16'h0018);
        bus_running_state = 1'b1;
        pkts = 0;
        u_host.cmd(8'hC1);
        for (int i = 0; i < 12; i++) u_host.wr(lst[i]);
        repeat (40) @(posedge core_clk);
        #1;
        `CHK(pkts, 0, "list without terminator sent packets")
        `CHK(state[BS_ACK_DONE], 1'b0, "ack done without terminator")
        `CHK(irq[IRQ_ACK_LIST], 1'b0, "ack irq without terminator")
        `CHK(irq[IRQ_ALL_DONE], 1'b1, "all done after short list")
        bus_running_state = 1'b0;
    endtask
    task automatic sof();
        @(posedge core_clk) #1;
        frame_start = 1'b1;
        @(posedge core_clk) #1;
        frame_start = 1'b0;
    endtask
    task automatic t_iso();
        logic [15:0] v;
        u_host.cmd(8'hC0);
        for (int i = 0; i < 4; i++) u_host.wr(16'hA000 + 16'(i));
        reg_rd(8'h2C, v);
        `CHK(v[BS_ISO_A_FULL], 1'b1, "iso half a full")
        sof();
        u_host.cmd(8'hC0);
        for (int i = 0; i < 4; i++) u_host.wr(16'hB000 + 16'(i));
        reg_rd(8'h2C, v);
        `CHK(v[BS_ISO_B_FULL], 1'b1, "iso half b full after swap")
        `CHK(v[BS_ISO_A_FULL], 1'b1, "iso half a still full")
        sof();
        u_host.cmd(8'h40);
        u_host.rd(v);
        `CHK(v, 16'hB000, "both full: host stays on half b")
        u_host.rd(v);
        `CHK(v, 16'hB001, "iso pointer advance")
    endtask

    initial begin
        lst[0] = 16'h0810;
        lst[1] = 16'h0008;
        lst[2] = 16'h0000;
        lst[3] = 16'h0000;
        // Even byte in the low half, odd byte in the high half
        for (int i = 0; i < 8; i++) lst[4 + i] = {8'(2 * i + 1), 8'(2 * i)};
        lst[12] = 16'h0000;
        lst[13] = 16'h0008;
        lst[14] = 16'h0000;
        lst[15] = 16'h0000;
        repeat (2) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        t_reset();
        t_ack_idle();
        t_ack_run();
        t_no_dummy();
        t_iso();
        results();
    end
endmodule
